// *** rtl/paged_address_translation_unit.sv ***
`timescale 1ns/100ps
module paged_address_translation_unit
   import patu_pkg::*;
(
   input  wire logic                              REF_CLK,
   input  wire logic                              RESET_N,
   input  wire logic [7:0]                        REG_ADDR,
   input  wire logic                              REG_WRITE,
   input  wire logic [15:0]                       REG_WDATA,
   output logic      [15:0]                       REG_RDATA,
   input  wire logic                              ACC_REQ,
   input  wire logic                              ACC_WRITE,
   input  wire logic                              ACC_INSTR,
   input  wire logic                              ACC_FETCH_START,
   input  wire patu_pkg::cpu_mode_type            ACC_MODE,
   input  wire logic [patu_pkg::VADDR_WIDTH-1:0]  ACC_VADDR,
   input  wire logic                              REGCHG_VALID,
   input  wire logic [2:0]                        REGCHG_REG,
   input  wire logic [4:0]                        REGCHG_AMOUNT,
   output logic                                   MEM_REQ,
   output logic                                   MEM_WRITE,
   output logic      [patu_pkg::PADDR_WIDTH-1:0]  MEM_PADDR,
   output logic                                   MEM_BYPASS_CACHE,
   output logic                                   TRAP,
   output logic                                   MAP_OUTPUT_EN,
   output logic                                   CSM_ENABLE
);
   import patu_pkg::*;

   function automatic logic [1:0] mode_index(input cpu_mode_type mode);
      case (mode)
         MODE_KERNEL:     mode_index = 2'h0;
         MODE_SUPERVISOR: mode_index = 2'h1;
         default:         mode_index = 2'h2;
      endcase
   endfunction

   logic [15:0] page_base [NUM_SPACES][NUM_MODES][NUM_PAGES];
   logic [15:0] page_desc [NUM_SPACES][NUM_MODES][NUM_PAGES];
   logic [15:0] next_page_base [NUM_SPACES][NUM_MODES][NUM_PAGES];
   logic [15:0] next_page_desc [NUM_SPACES][NUM_MODES][NUM_PAGES];
   logic [15:0] translation_status_control;
   logic [15:0] register_change_log;
   logic [15:0] fetch_address_log;
   logic [15:0] translation_feature_control;
   logic [15:0] next_translation_status_control;
   logic [15:0] next_register_change_log;
   logic [15:0] next_fetch_address_log;
   logic [15:0] next_translation_feature_control;
   logic        change_second;
   logic        next_change_second;
   logic [15:0] next_reg_rdata;
   logic                   next_mem_req;
   logic                   next_mem_write;
   logic [PADDR_WIDTH-1:0] next_mem_paddr;
   logic                   next_mem_bypass;
   logic                   next_trap;

   logic                   page_access;
   logic                   reg_space;
   logic [1:0]             reg_mode;
   logic [2:0]             reg_page;
   logic                   acc_space;
   logic [1:0]             acc_mode;
   logic [2:0]             acc_page;
   logic [15:0]            sel_base;
   logic [15:0]            sel_desc;
   logic                   enabled;
   logic                   wide;
   logic                   frozen;
   logic                   abort;
   logic [PADDR_WIDTH-1:0] mapped_paddr;
   logic                   nonres_err;
   logic                   length_err;
   logic                   readonly_err;
   logic [2:0]             data_space_en;

   always_comb begin
      page_access = (REG_ADDR & ADDR_PAGE_FLAG) != 8'h00;
      reg_space   = REG_ADDR[ADDR_SPACE_BIT];
      reg_mode    = REG_ADDR[ADDR_MODE_LSB+1:ADDR_MODE_LSB];
      reg_page    = REG_ADDR[2:0];
      enabled     = translation_status_control[STAT_ENABLE];
      wide        = translation_feature_control[FEAT_WIDE];
      frozen      = translation_status_control[STAT_NONRES] | translation_status_control[STAT_LENGTH] |
                    translation_status_control[STAT_READONLY];
      data_space_en = {translation_feature_control[FEAT_DS_KERN], translation_feature_control[FEAT_DS_SUP],
                       translation_feature_control[FEAT_DS_USER]};
      acc_mode    = mode_index(ACC_MODE);
      acc_page    = ACC_VADDR[VADDR_WIDTH-1:VADDR_WIDTH-3];
      acc_space   = !ACC_INSTR && data_space_en[2'h2 - acc_mode];
      sel_base    = page_base[acc_space][acc_mode][acc_page];
      sel_desc    = page_desc[acc_space][acc_mode][acc_page];
   end

   page_translate u_translate (
      .page_base    (sel_base),
      .page_desc    (sel_desc),
      .vaddr        (ACC_VADDR),
      .write        (ACC_WRITE),
      .wide         (wide),
      .paddr        (mapped_paddr),
      .nonres_err   (nonres_err),
      .length_err   (length_err),
      .readonly_err (readonly_err)
   );

   always_comb begin
      abort = ACC_REQ && enabled && (nonres_err || length_err || readonly_err);
   end

   // page register file
   always_comb begin
      next_page_base = page_base;
      next_page_desc = page_desc;
      if (REG_WRITE && page_access && reg_mode != 2'h3) begin
         if (REG_ADDR[ADDR_DESC_BIT]) begin
            next_page_desc[reg_space][reg_mode][reg_page] = REG_WDATA & DESC_WRITE_MASK;
         end else begin
            next_page_base[reg_space][reg_mode][reg_page] = REG_WDATA;
            next_page_desc[reg_space][reg_mode][reg_page][DESC_WRITTEN] = 1'b0;
         end
      end
      if (ACC_REQ && ACC_WRITE && enabled && !abort) begin
         next_page_desc[acc_space][acc_mode][acc_page][DESC_WRITTEN] = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int s = 0; s < NUM_SPACES; s++) begin
            for (int m = 0; m < NUM_MODES; m++) begin
               for (int p = 0; p < NUM_PAGES; p++) begin
                  page_base[s][m][p] <= 16'h0000;
                  page_desc[s][m][p] <= 16'h0000;
               end
            end
         end
      end else begin
         page_base <= next_page_base;
         page_desc <= next_page_desc;
      end
   end

   // status and control registers
   always_comb begin
      next_translation_status_control  = translation_status_control;
      next_translation_feature_control = translation_feature_control;
      next_fetch_address_log           = fetch_address_log;
      next_register_change_log         = register_change_log;
      next_change_second               = change_second;
      if (REG_WRITE && REG_ADDR == ADDR_STATUS) begin
         next_translation_status_control = (translation_status_control & ~STAT_WRITE_MASK) |
                                           (REG_WDATA & STAT_WRITE_MASK);
      end
      if (REG_WRITE && REG_ADDR == ADDR_FEATURE) begin
         next_translation_feature_control = REG_WDATA & FEAT_WRITE_MASK;
      end
      // a fresh abort wins over a clearing write in the same cycle
      if (abort && (!frozen || (REG_WRITE && REG_ADDR == ADDR_STATUS))) begin
         next_translation_status_control[STAT_NONRES]   = nonres_err;
         next_translation_status_control[STAT_LENGTH]   = length_err && !nonres_err;
         next_translation_status_control[STAT_READONLY] = readonly_err && !nonres_err;
         next_translation_status_control[STAT_MODE_LSB+1:STAT_MODE_LSB] = ACC_MODE;
         next_translation_status_control[STAT_PAGE_LSB+2:STAT_PAGE_LSB] = acc_page;
      end
      if (!frozen) begin
         if (ACC_REQ && ACC_INSTR && ACC_FETCH_START) begin
            next_fetch_address_log   = ACC_VADDR;
            next_register_change_log = 16'h0000;
            next_change_second       = 1'b0;
         end else if (REGCHG_VALID) begin
            if (change_second) begin
               next_register_change_log[15:8] = {REGCHG_AMOUNT, REGCHG_REG};
            end else begin
               next_register_change_log[7:0] = {REGCHG_AMOUNT, REGCHG_REG};
               next_change_second            = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         translation_status_control  <= STATUS_RESET;
         translation_feature_control <= FEATURE_RESET;
         fetch_address_log           <= 16'h0000;
         register_change_log         <= 16'h0000;
         change_second               <= 1'b0;
      end else begin
         translation_status_control  <= next_translation_status_control;
         translation_feature_control <= next_translation_feature_control;
         fetch_address_log           <= next_fetch_address_log;
         register_change_log         <= next_register_change_log;
         change_second               <= next_change_second;
      end
   end

   // read port, one cycle latency
   always_comb begin
      next_reg_rdata = 16'h0000;
      if (page_access) begin
         if (reg_mode != 2'h3) begin
            next_reg_rdata = REG_ADDR[ADDR_DESC_BIT] ? page_desc[reg_space][reg_mode][reg_page] :
                                                       page_base[reg_space][reg_mode][reg_page];
         end
      end else begin
         case (REG_ADDR)
            ADDR_STATUS:     next_reg_rdata = translation_status_control;
            ADDR_CHANGE_LOG: next_reg_rdata = register_change_log;
            ADDR_FETCH_LOG:  next_reg_rdata = fetch_address_log;
            ADDR_FEATURE:    next_reg_rdata = translation_feature_control & FEAT_WRITE_MASK;
            default:         next_reg_rdata = 16'h0000;
         endcase
      end
   end

   // memory side
   always_comb begin
      next_mem_req    = ACC_REQ && !abort;
      next_mem_write  = ACC_REQ && ACC_WRITE && !abort;
      next_mem_paddr  = MEM_PADDR;
      next_mem_bypass = 1'b0;
      next_trap       = abort;
      if (ACC_REQ) begin
         if (enabled) begin
            next_mem_paddr  = mapped_paddr;
            next_mem_bypass = sel_desc[DESC_BYPASS] && !abort;
         end else begin
            next_mem_paddr  = PADDR_WIDTH'(ACC_VADDR);
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA        <= 16'h0000;
         MEM_REQ          <= 1'b0;
         MEM_WRITE        <= 1'b0;
         MEM_PADDR        <= '0;
         MEM_BYPASS_CACHE <= 1'b0;
         TRAP             <= 1'b0;
      end else begin
         REG_RDATA        <= next_reg_rdata;
         MEM_REQ          <= next_mem_req;
         MEM_WRITE        <= next_mem_write;
         MEM_PADDR        <= next_mem_paddr;
         MEM_BYPASS_CACHE <= next_mem_bypass;
         TRAP             <= next_trap;
      end
   end

   always_comb begin
      MAP_OUTPUT_EN = translation_feature_control[FEAT_MAP_OUT];
      CSM_ENABLE    = translation_feature_control[FEAT_CSM];
   end

   AST_PADDR_FORM: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && enabled && wide && !abort |=> MEM_REQ &&
      MEM_PADDR == PADDR_WIDTH'({$past(sel_base), 6'h00}) + PADDR_WIDTH'($past(ACC_VADDR[12:0])))
      else $error("physical address not base plus displacement");

   AST_UNMAPPED: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && !enabled |=> MEM_REQ && MEM_PADDR == PADDR_WIDTH'($past(ACC_VADDR)) && !TRAP)
      else $error("unmapped access altered the address");

   AST_NARROW: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && enabled && !wide |=> MEM_PADDR[21:18] == 4'h0)
      else $error("18-bit mapping produced high address bits");

   AST_NONRES: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && enabled && sel_desc[2:1] == ACF_NONRES |=> TRAP && !MEM_REQ)
      else $error("non-resident page reached memory");

   AST_RO_WRITE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && enabled && ACC_WRITE && sel_desc[2:1] == ACF_READ_ONLY && !frozen
      |=> TRAP ##1 translation_status_control[STAT_READONLY])
      else $error("read-only write not aborted and logged");

   AST_FREEZE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      frozen && !(REG_WRITE && REG_ADDR == ADDR_STATUS) |=> $stable(translation_status_control[15:1]))
      else $error("abort status changed while frozen");

   AST_FEATURE_ZERO: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      REG_ADDR == ADDR_FEATURE |=> REG_RDATA[15:6] == 10'h000)
      else $error("feature control upper bits not zero");

   AST_BYPASS: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && enabled && !abort |=> MEM_BYPASS_CACHE == $past(sel_desc[DESC_BYPASS]))
      else $error("cache bypass does not follow descriptor");

   AST_LENGTH: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && enabled && !sel_desc[DESC_DOWN] && sel_desc[2:1] == ACF_FULL &&
      ACC_VADDR[12:6] > sel_desc[14:8] |=> TRAP)
      else $error("reference beyond page length not aborted");

   AST_LENGTH_DOWN: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && enabled && sel_desc[DESC_DOWN] && sel_desc[2:1] == ACF_FULL &&
      ACC_VADDR[12:6] < sel_desc[14:8] |=> TRAP)
      else $error("reference below downward page length not aborted");

   AST_WRITTEN_SET: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && ACC_WRITE && enabled && !abort |=>
      page_desc[$past(acc_space)][$past(acc_mode)][$past(acc_page)][DESC_WRITTEN])
      else $error("written flag not set by a mapped write");

   AST_ABORT_LOG: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      abort && !frozen |=> translation_status_control[6:5] == $past(ACC_MODE) &&
      translation_status_control[3:1] == $past(acc_page))
      else $error("abort mode or page not logged");

   AST_LENGTH_LOG: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      abort && !frozen && length_err && !nonres_err |=> translation_status_control[STAT_LENGTH])
      else $error("length abort not logged");

   AST_ABORT_BLOCKED: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      abort |=> TRAP && !MEM_REQ && !MEM_WRITE)
      else $error("aborted reference reached memory");

   AST_FETCH_LOG: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      ACC_REQ && ACC_INSTR && ACC_FETCH_START && !frozen |=> fetch_address_log == $past(ACC_VADDR))
      else $error("fetch address not logged");
endmodule

// *** rtl/patu_pkg.sv ***
package patu_pkg;

   // geometry
   localparam int NUM_PAGES    = 8;
   localparam int NUM_MODES    = 3;
   localparam int NUM_SPACES   = 2;
   localparam int VADDR_WIDTH  = 16;
   localparam int PADDR_WIDTH  = 22;
   localparam int NARROW_WIDTH = 18;
   localparam int BLOCK_SHIFT  = 6;
   localparam int DISP_WIDTH   = 13;

   // register address layout: bit 7 page registers, bit 6 descriptor, bit 5 data space
   localparam logic [7:0] ADDR_PAGE_FLAG  = 8'h80;
   localparam int         ADDR_DESC_BIT   = 6;
   localparam int         ADDR_SPACE_BIT  = 5;
   localparam int         ADDR_MODE_LSB   = 3;
   localparam logic [7:0] ADDR_STATUS     = 8'h00;
   localparam logic [7:0] ADDR_CHANGE_LOG = 8'h01;
   localparam logic [7:0] ADDR_FETCH_LOG  = 8'h02;
   localparam logic [7:0] ADDR_FEATURE    = 8'h03;

   // descriptor fields
   localparam int DESC_BYPASS  = 15;
   localparam int DESC_LEN_MSB = 14;
   localparam int DESC_LEN_LSB = 8;
   localparam int DESC_WRITTEN = 6;
   localparam int DESC_DOWN    = 3;
   localparam int DESC_ACF_MSB = 2;
   localparam int DESC_ACF_LSB = 1;
   localparam logic [15:0] DESC_WRITE_MASK = 16'hff0e;

   // access control codes
   localparam logic [1:0] ACF_NONRES    = 2'h0;
   localparam logic [1:0] ACF_READ_ONLY = 2'h1;
   localparam logic [1:0] ACF_UNUSED    = 2'h2;
   localparam logic [1:0] ACF_FULL      = 2'h3;

   // status/control fields
   localparam int STAT_NONRES   = 15;
   localparam int STAT_LENGTH   = 14;
   localparam int STAT_READONLY = 13;
   localparam int STAT_MODE_LSB = 5;
   localparam int STAT_PAGE_LSB = 1;
   localparam int STAT_ENABLE   = 0;
   localparam logic [15:0] STAT_WRITE_MASK = 16'he001;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;

   // feature control fields
   localparam int FEAT_MAP_OUT = 5;
   localparam int FEAT_WIDE    = 4;
   localparam int FEAT_CSM     = 3;
   localparam int FEAT_DS_KERN = 2;
   localparam int FEAT_DS_SUP  = 1;
   localparam int FEAT_DS_USER = 0;
   localparam logic [15:0] FEAT_WRITE_MASK = 16'h003f;
   localparam logic [15:0] FEATURE_RESET   = 16'h0000;

   // processor mode codes as in the processor status word
   typedef enum logic [1:0] {
      MODE_KERNEL     = 2'h0,
      MODE_SUPERVISOR = 2'h1,
      MODE_ILLEGAL    = 2'h2,
      MODE_USER       = 2'h3
   } cpu_mode_type;

endpackage

// *** rtl/page_translate.sv ***
`timescale 1ns/100ps
module page_translate
   import patu_pkg::*;
(
   input  wire logic [15:0]             page_base,
   input  wire logic [15:0]             page_desc,
   input  wire logic [VADDR_WIDTH-1:0]  vaddr,
   input  wire logic                    write,
   input  wire logic                    wide,
   output logic      [PADDR_WIDTH-1:0]  paddr,
   output logic                         nonres_err,
   output logic                         length_err,
   output logic                         readonly_err
);
   logic [6:0]             block;
   logic [6:0]             length;
   logic [1:0]             acf;
   logic [PADDR_WIDTH-1:0] sum;

   always_comb begin
      block  = vaddr[DISP_WIDTH-1:BLOCK_SHIFT];
      length = page_desc[DESC_LEN_MSB:DESC_LEN_LSB];
      acf    = page_desc[DESC_ACF_MSB:DESC_ACF_LSB];
      sum    = PADDR_WIDTH'({page_base, 6'h00}) + PADDR_WIDTH'(vaddr[DISP_WIDTH-1:0]);
      paddr  = wide ? sum : {4'h0, sum[NARROW_WIDTH-1:0]};
      nonres_err   = (acf == ACF_NONRES) || (acf == ACF_UNUSED);
      readonly_err = (acf == ACF_READ_ONLY) && write;
      if (page_desc[DESC_DOWN]) begin
         length_err = block < length;
      end else begin
         length_err = block > length;
      end
   end
endmodule

// *** verif/cpu_core_model.sv ***
`timescale 1ns/100ps
module cpu_core_model (
   input  wire logic             ref_clk,
   output logic                  acc_req,
   output logic                  acc_write,
   output logic                  acc_instr,
   output logic                  acc_fetch_start,
   output patu_pkg::cpu_mode_type acc_mode,
   output logic [15:0]           acc_vaddr,
   output logic                  chg_valid,
   output logic [2:0]            chg_reg,
   output logic [4:0]            chg_amount
);
   import patu_pkg::*;
   initial begin
      acc_req = 1'b0;
      acc_write = 1'b0;
      acc_instr = 1'b0;
      acc_fetch_start = 1'b0;
      acc_mode = MODE_KERNEL;
      acc_vaddr = 16'h0000;
      chg_valid = 1'b0;
      chg_reg = 3'h0;
      chg_amount = 5'h00;
   end
   // one access across one taking edge; released write and address lines show the inverse, fetch start returns low
   task access(input cpu_mode_type m, input logic i, w, f, input logic [15:0] va);
      @(negedge ref_clk);
      acc_req = 1'b1;
      acc_mode = m;
      acc_instr = i;
      acc_write = w;
      acc_fetch_start = f;
      acc_vaddr = va;
      @(negedge ref_clk);
      acc_req = 1'b0;
      acc_write = ~w;
      acc_fetch_start = 1'b0;
      acc_vaddr = ~va;
   endtask
   // one general register change report
   task reg_change(input logic [2:0] r, input logic [4:0] a);
      @(negedge ref_clk);
      chg_valid = 1'b1;
      chg_reg = r;
      chg_amount = a;
      @(negedge ref_clk);
      chg_valid = 1'b0;
      chg_reg = ~r;
      chg_amount = ~a;
   endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   import patu_pkg::*;
   localparam logic [15:0] DSC [8] = '{16'h7f00, 16'h7f04, 16'h7f02, 16'h7f02,
                                       16'h0006, 16'h0006, 16'h7e0e, 16'h7e0e};
   localparam logic [15:0] VA [8]  = '{16'h4000, 16'h6000, 16'h8000, 16'h8010,
                                       16'ha040, 16'ha03f, 16'hc000, 16'hdfc0};
   // mode and page fields survive the clearing write, so clean steps still show the last abort
   localparam logic [15:0] ST [8]  = '{16'h8065, 16'h8067, 16'h2069, 16'h0069,
                                       16'h406b, 16'h006b, 16'h406d, 16'h006d};
   localparam logic        WR [8]  = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
   logic         ref_clk = 1'b0;
   logic         reset_n = 1'b0;
   logic [7:0]   reg_addr = 8'h00;
   logic         reg_write = 1'b0;
   logic [15:0]  reg_wdata = 16'h0000;
   logic [15:0]  rdata, rd, va;
   logic         req, wr, ins, fst, cv, mreq, mwr, byp, trap, mapen, call_to_supervisor_instruction;
   cpu_mode_type mode;
   logic [2:0]   cr;
   logic [4:0]   ca;
   logic [21:0]  pa;
   int           num_errors = 0;
   int           check_count = 0;
   always #25 ref_clk = ~ref_clk;
   paged_address_translation_unit DUT (.REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
      .REG_WRITE(reg_write), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .ACC_REQ(req), .ACC_WRITE(wr),
      .ACC_INSTR(ins), .ACC_FETCH_START(fst), .ACC_MODE(mode), .ACC_VADDR(va), .REGCHG_VALID(cv),
      .REGCHG_REG(cr), .REGCHG_AMOUNT(ca), .MEM_REQ(mreq), .MEM_WRITE(mwr), .MEM_PADDR(pa),
      .MEM_BYPASS_CACHE(byp), .TRAP(trap), .MAP_OUTPUT_EN(mapen), .CSM_ENABLE(call_to_supervisor_instruction));
   cpu_core_model cpu (.ref_clk(ref_clk), .acc_req(req), .acc_write(wr), .acc_instr(ins),
      .acc_fetch_start(fst), .acc_mode(mode), .acc_vaddr(va), .chg_valid(cv), .chg_reg(cr),
      .chg_amount(ca));
   task check(input string what, input logic [23:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_write = 1'b1;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_write = 1'b0;
   endtask
   task reg_rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      repeat (2) @(negedge ref_clk);
      d = rdata;
   endtask
   function automatic logic [7:0] pg(input logic d, s, input logic [1:0] m, input logic [2:0] p);
      return {1'b1, d, s, m, p};
   endfunction
   // answer stands for the one cycle after the taking edge
   task acc_chk(input cpu_mode_type m, input logic i, w, input logic [15:0] v, input logic tr,
                input logic [21:0] epa);
      cpu.access(m, i, w, 1'b0, v);
      check("trap", trap, tr);
      check("mem_req", mreq, !tr);
      if (!tr) begin
         check("mem_paddr", pa, epa);
         check("mem_write", mwr, w);
      end
   endtask
   task t_reset;
      reg_rd(ADDR_STATUS, rd);
      check("status", rd, 16'h0000);
      reg_rd(ADDR_FEATURE, rd);
      check("feature", rd, 16'h0000);
      reg_rd(8'h10, rd);
      check("unmapped", rd, 16'h0000);
      acc_chk(MODE_USER, 1'b0, 1'b1, 16'habcd, 1'b0, 22'h00abcd);
      $display("done reset");
   endtask
   task t_logs;
      cpu.access(MODE_KERNEL, 1'b1, 1'b0, 1'b1, 16'h1234);
      cpu.reg_change(3'h3, 5'h1e);
      cpu.reg_change(3'h5, 5'h02);
      reg_rd(ADDR_FETCH_LOG, rd);
      check("fetch_log", rd, 16'h1234);
      reg_rd(ADDR_CHANGE_LOG, rd);
      check("change_log", rd, 16'h15f3);
      $display("done logs");
   endtask
   task t_feature;
      reg_wr(ADDR_FEATURE, 16'hffff);
      reg_rd(ADDR_FEATURE, rd);
      check("feature", rd, 16'h003f);
      check("map_out", mapen, 1'b1);
      check("csm", call_to_supervisor_instruction, 1'b1);
      reg_wr(ADDR_FEATURE, 16'h0010);
      reg_rd(ADDR_FEATURE, rd);
      check("feature", rd, 16'h0010);
      check("map_out", mapen, 1'b0);
      check("csm", call_to_supervisor_instruction, 1'b0);
      $display("done feature");
   endtask
   task t_map;
      reg_wr(pg(1'b0, 1'b0, 2'h0, 3'h1), 16'h1100);
      reg_wr(pg(1'b1, 1'b0, 2'h0, 3'h1), 16'h7f06);
      reg_wr(ADDR_STATUS, 16'h0001);
      acc_chk(MODE_KERNEL, 1'b1, 1'b0, 16'h2004, 1'b0, 22'h044004);
      check("bypass", byp, 1'b0);
      acc_chk(MODE_KERNEL, 1'b1, 1'b1, 16'h3ffe, 1'b0, 22'h045ffe);
      reg_rd(pg(1'b1, 1'b0, 2'h0, 3'h1), rd);
      check("desc", rd, 16'h7f46);
      reg_wr(pg(1'b0, 1'b0, 2'h0, 3'h1), 16'h1100);
      reg_rd(pg(1'b1, 1'b0, 2'h0, 3'h1), rd);
      check("desc", rd, 16'h7f06);
      reg_wr(pg(1'b1, 1'b0, 2'h0, 3'h1), 16'hff06);
      acc_chk(MODE_KERNEL, 1'b1, 1'b0, 16'h2004, 1'b0, 22'h044004);
      check("bypass", byp, 1'b1);
      reg_wr(ADDR_FEATURE, 16'h0000);
      acc_chk(MODE_KERNEL, 1'b1, 1'b0, 16'h2004, 1'b0, 22'h004004);
      reg_wr(ADDR_FEATURE, 16'h0014);
      reg_wr(pg(1'b0, 1'b1, 2'h0, 3'h1), 16'h0200);
      reg_wr(pg(1'b1, 1'b1, 2'h0, 3'h1), 16'h7f06);
      acc_chk(MODE_KERNEL, 1'b0, 1'b0, 16'h2004, 1'b0, 22'h008004);
      acc_chk(MODE_KERNEL, 1'b1, 1'b0, 16'h2004, 1'b0, 22'h044004);
      $display("done map");
   endtask
   task t_aborts;
      for (int k = 0; k < 8; k++) begin
         reg_wr(pg(1'b1, 1'b0, 2'h2, VA[k][15:13]), DSC[k]);
         acc_chk(MODE_USER, 1'b1, WR[k], VA[k], ST[k][15:13] != 3'h0, {9'h000, VA[k][12:0]});
         reg_rd(ADDR_STATUS, rd);
         check("status", rd, ST[k] | 16'h0001);
         if (ST[k][15:13] != 3'h0) begin
            acc_chk(MODE_USER, 1'b1, 1'b0, 16'he000, 1'b1, 22'h000000);
            reg_rd(ADDR_STATUS, rd);
            check("frozen", rd, ST[k] | 16'h0001);
            reg_wr(ADDR_STATUS, 16'h0001);
         end
      end
      $display("done aborts");
   endtask
   initial begin
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      t_reset();
      t_logs();
      t_feature();
      t_map();
      t_aborts();
      final_report();
   end
   initial begin
      #2000000;
      num_errors++;
      final_report();
   end
endmodule
